/* File: core/apc_pkg.sv */
// package: constants and carrier types for the parallel conversion port
package apc_pkg;
	localparam int unsigned RESULT_W         = 10;
	localparam int unsigned CLK_HZ           = 40000000;
	// internal converter clock rate
	localparam int unsigned INT_CLK_HZ       = 4000000;
	localparam int unsigned INT_DIV          = CLK_HZ / INT_CLK_HZ;
	// converter clock cycles per conversion
	localparam int unsigned CONV_CYCLES      = 24;
	// switchover to an external clock, in microseconds
	localparam int unsigned SWITCH_US        = 2;
	localparam int unsigned SWITCH_CYCLES    = SWITCH_US * (CLK_HZ / 1000000);
	localparam logic [9:0]  RESULT_ALL_ONES  = 10'h3ff;
	localparam logic [9:0]  RESULT_ALL_ZEROS = 10'h000;
	localparam logic [9:0]  RESULT_RST       = 10'h000;

	typedef enum logic [2:0] {
		APC_SAMPLE = 3'h1,
		APC_CONV   = 3'h2,
		APC_DONE   = 3'h4
	} apc_state_t;

	// host strobes, all active low
	typedef struct packed {
		logic chip_select_n;
		logic read_n;
		logic write_n;
	} apc_host_t;

	// analog front end, sample and references as codes
	typedef struct packed {
		logic [15:0] analog_input;
		logic [15:0] ref_low;
		logic [15:0] ref_high;
	} apc_analog_t;

	// result bus pins
	typedef struct packed {
		logic [9:0] data_out;
		logic [9:0] data_oe;
	} apc_bus_t;
endpackage : apc_pkg

/* File: core/apc_conversion_port.sv */
// module: converter control and parallel host port
`timescale 1ns/10ps
module apc_conversion_port #(
	parameter int unsigned CONV_LEN   = apc_pkg::CONV_CYCLES,
	parameter int unsigned SWITCH_LEN = apc_pkg::SWITCH_CYCLES
) (
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	input  wire apc_pkg::apc_host_t   host,
	input  wire apc_pkg::apc_analog_t analog,
	input  wire logic                 external_clock_in,
	output logic                      conv_done_n,
	output logic                      sampling,
	output logic                      ext_clock_active,
	output apc_pkg::apc_bus_t         result_bus
);
	import apc_pkg::*;

	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	// counters are eight bits wide, so longer counts cannot be served
	if (CONV_LEN < 1 || CONV_LEN > 255) begin : g_bad_conv_len
		$error("apc_conversion_port: CONV_LEN must lie in 1..255");
	end
	if (SWITCH_LEN < 1 || SWITCH_LEN > 255) begin : g_bad_switch_len
		$error("apc_conversion_port: SWITCH_LEN must lie in 1..255");
	end
	if (INT_DIV < 1 || INT_DIV > 256) begin : g_bad_int_div
		$error("apc_conversion_port: internal divider must lie in 1..256");
	end

	// ----------------------------------------
	// converter arithmetic
	// ----------------------------------------
	// offset over span, scaled to the full code range
	function automatic logic [9:0] to_code(input logic [15:0] vin, input logic [15:0] lo,
		input logic [15:0] hi);
		logic [31:0] num;
		logic [31:0] q;
		num = 32'h0;
		q   = 32'h0;
		if (vin >= hi) begin
			to_code = RESULT_ALL_ONES;
		end else if (vin <= lo) begin
			to_code = RESULT_ALL_ZEROS;
		end else begin
			num     = 32'(vin - lo) * 32'(RESULT_ALL_ONES);
			q       = num / 32'(hi - lo);
			to_code = q[9:0];
		end
	endfunction : to_code

	// ----------------------------------------
	// edge and counter helpers
	// ----------------------------------------
	function automatic logic edge_up(input logic prev, input logic now);
		edge_up = !prev && now;
	endfunction : edge_up

	function automatic logic edge_down(input logic prev, input logic now);
		edge_down = prev && !now;
	endfunction : edge_down

	// eight-bit step; callers guard the wrap themselves
	function automatic logic [7:0] bump(input logic [7:0] cnt);
		bump = cnt + 8'h01;
	endfunction : bump

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		apc_state_t  state;
		logic [7:0]  conv_cnt;
		logic [7:0]  div_cnt;
		logic [7:0]  sw_cnt;
		logic        ext_sel;
		logic        ext_prev;
		logic        wr_prev;
		logic        rd_prev;
		logic [15:0] held;
		logic [9:0]  latch;
		logic        done_n;
		logic        sample_out;
		logic        bus_oe;
	} apc_regs_t;

	apc_regs_t state_reg;
	apc_regs_t state_next;
	logic      conv_tick;
	logic      sel;
	logic      rd_fall;
	logic      wr_rise;
	logic      div_wrap;
	logic      ext_tick;
	logic      conv_last;
	logic      done_set;

	always_comb begin
		state_next = state_reg;

		// ----------------------------------------
		// strobe decoding
		// ----------------------------------------
		sel                 = !host.chip_select_n;
		rd_fall             = sel && edge_down(state_reg.rd_prev, host.read_n);
		wr_rise             = sel && edge_up(state_reg.wr_prev, host.write_n);
		state_next.wr_prev  = host.write_n;
		state_next.rd_prev  = host.read_n;
		state_next.ext_prev = external_clock_in;

		// ----------------------------------------
		// converter clock
		// ----------------------------------------
		div_wrap  = state_reg.div_cnt == 8'(INT_DIV - 1);
		ext_tick  = edge_up(state_reg.ext_prev, external_clock_in);
		// the pin only clocks the converter once the switchover is done
		conv_tick = state_reg.ext_sel ? ext_tick : div_wrap;
		conv_last = state_reg.conv_cnt == 8'(CONV_LEN - 1);
		done_set  = state_reg.state == APC_CONV && conv_tick && conv_last;
		if (div_wrap) begin
			state_next.div_cnt = 8'h00;
		end else begin
			state_next.div_cnt = bump(state_reg.div_cnt);
		end

		// ----------------------------------------
		// clock switchover
		// ----------------------------------------
		// first low on the pin starts the count; a pin held high never starts it
		if (state_reg.sw_cnt == 8'(SWITCH_LEN)) begin
			state_next.sw_cnt = state_reg.sw_cnt;
		end else if (!external_clock_in || state_reg.sw_cnt != 8'h00) begin
			state_next.sw_cnt = bump(state_reg.sw_cnt);
		end
		// handover waits for idle so one conversion never mixes two clocks; no return short of reset
		if (state_reg.sw_cnt == 8'(SWITCH_LEN) && state_reg.state != APC_CONV) begin
			state_next.ext_sel = 1'b1;
		end

		// ----------------------------------------
		// conversion sequence
		// ----------------------------------------
		case (state_reg.state)
			APC_SAMPLE, APC_DONE: begin
				state_next.held = analog.analog_input;
				if (wr_rise) begin
					state_next.state    = APC_CONV;
					state_next.held     = analog.analog_input;
					state_next.conv_cnt = 8'h00;
					// raised on start so every new result gets its own falling edge
					state_next.done_n   = 1'b1;
				end
			end
			APC_CONV: begin
				// write strobes are ignored, not held, while the running conversion lasts
				if (conv_tick) begin
					state_next.conv_cnt = bump(state_reg.conv_cnt);
				end
				if (done_set) begin
					state_next.state  = APC_DONE;
					state_next.latch  = to_code(state_reg.held, analog.ref_low, analog.ref_high);
					state_next.done_n = 1'b0;
				end
			end
			default: begin
				state_next.state = APC_SAMPLE;
			end
		endcase

		// ----------------------------------------
		// done flag and bus enable
		// ----------------------------------------
		// a new result wins over a read edge in the same cycle
		if (rd_fall && !done_set) begin
			state_next.done_n = 1'b1;
		end
		state_next.bus_oe     = sel && !host.read_n;
		state_next.sample_out = state_next.state != APC_CONV;

		// ----------------------------------------
		// synchronous reset
		// ----------------------------------------
		if (reset) begin
			state_next            = '0;
			state_next.state      = APC_SAMPLE;
			state_next.latch      = RESULT_RST;
			state_next.done_n     = 1'b1;
			state_next.sample_out = 1'b1;
			state_next.wr_prev    = 1'b1;
			state_next.rd_prev    = 1'b1;
			state_next.ext_prev   = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign conv_done_n         = state_reg.done_n;
	assign sampling            = state_reg.sample_out;
	assign ext_clock_active    = state_reg.ext_sel;
	assign result_bus.data_out = state_reg.latch;
	assign result_bus.data_oe  = {RESULT_W{state_reg.bus_oe}};
endmodule : apc_conversion_port

/* File: verification/apc_conversion_port_chk.sv */
// checker: port timing of the conversion port
`timescale 1ns/10ps
module apc_conversion_port_chk #(
	parameter int unsigned CONV_LEN = 24
) (
	input wire logic               ref_clk,
	input wire logic               reset,
	input wire apc_pkg::apc_host_t host,
	input wire logic               conv_done_n,
	input wire logic               sampling,
	input wire logic               ext_clock_active,
	input wire apc_pkg::apc_bus_t  result_bus
);
	import apc_pkg::*;
	// wide window: internal tick phase is unknown at start
	localparam int LO = CONV_LEN * 10 - 20;
	localparam int HI = CONV_LEN * 10 + 5;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	bus_drive_a: assert property (!host.chip_select_n && !host.read_n |=> &result_bus.data_oe)
		else $error("bus not driven on read");
	bus_float_a: assert property (host.chip_select_n || host.read_n |=> result_bus.data_oe == '0)
		else $error("bus not released");
	done_clear_a: assert property ($fell(host.read_n) && !host.chip_select_n && sampling |=> conv_done_n)
		else $error("done not cleared by read");
	start_conv_a: assert property ($rose(host.write_n) && !host.chip_select_n && sampling |=> !sampling)
		else $error("conversion not started");
	strobe_ignore_a: assert property (host.chip_select_n && sampling |=> sampling)
		else $error("started without select");
	latch_hold_a: assert property (!$fell(conv_done_n) |-> $stable(result_bus.data_out))
		else $error("latch changed outside done edge");
	conv_len_a: assert property ($fell(sampling) |-> conv_done_n[*8] ##[LO:HI] $fell(conv_done_n))
		else $error("conversion length wrong");
	done_track_a: assert property ($fell(conv_done_n) |-> sampling && !$past(sampling))
		else $error("done without return to sampling");
	done_hold_a: assert property (!conv_done_n && host.chip_select_n |=> !conv_done_n)
		else $error("done cleared without a read");
	ext_hold_a: assert property (ext_clock_active |=> ext_clock_active)
		else $error("external clock selection dropped");
endmodule : apc_conversion_port_chk
bind apc_conversion_port apc_conversion_port_chk #(.CONV_LEN(CONV_LEN)) u_chk (.ref_clk, .reset, .host,
	.conv_done_n, .sampling, .ext_clock_active, .result_bus);

/* File: verification/apc_host_model.sv */
// host model: processor strobe sequences
`timescale 1ns/10ps
module apc_host_model (
	input  wire logic              ref_clk,
	input  wire logic              conv_done_n,
	input  wire apc_pkg::apc_bus_t result_bus,
	output apc_pkg::apc_host_t     host
);
	import apc_pkg::*;
	initial host = 3'b111;
	task automatic start(input logic sel_n);
		@(posedge ref_clk) #1;
		host = {sel_n, 2'b10};
		@(posedge ref_clk) #1;
		host.write_n = 1'b1;
		@(posedge ref_clk) #1;
		host = 3'b111;
	endtask : start
	// polls done as a status line, bounded so a dead device cannot hang us
	task automatic read(output logic [9:0] d);
		d = 'x;
		for (int n = 0; n < 100 && conv_done_n !== 1'b0; n++) begin
			@(posedge ref_clk);
			#1;
		end
		// no done in time leaves d unknown, which the bench counts as a mismatch
		if (conv_done_n === 1'b0) begin
			@(posedge ref_clk) #1;
			host = 3'b001;
			repeat (2) @(posedge ref_clk);
			#1;
			if (result_bus.data_oe === 10'h3ff) d = result_bus.data_out;
			host = 3'b111;
		end
	endtask : read
endmodule : apc_host_model

/* File: verification/testbench.sv */
// testbench: random and corner conversions
`timescale 1ns/10ps
module testbench;
	import apc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset   = 1'b1;
	apc_analog_t analog  = '0;
	apc_host_t   host;
	apc_bus_t    result_bus;
	logic        conv_done_n, sampling, ext_clock_active;
	int          err_count = 0;
	int          compares  = 0;
	logic [9:0]  got;
	logic [15:0] lo, hi, vin;
	logic        ext_in  = 1'b1;
	logic        ext_run = 1'b0;
	initial forever #12.5 ref_clk = ~ref_clk;
	// external converter clock at a tenth of the bench clock; idle level is high
	initial forever begin
		repeat (5) @(posedge ref_clk);
		#1 ext_in = ext_run ? ~ext_in : 1'b1;
	end
	apc_conversion_port #(.CONV_LEN(4), .SWITCH_LEN(4)) u_apc_conversion_port (.ref_clk, .reset, .host, .analog,
		.external_clock_in(ext_in), .conv_done_n, .sampling, .ext_clock_active, .result_bus);
	apc_host_model u_apc_host_model (.ref_clk, .conv_done_n, .result_bus, .host);
	function automatic logic [9:0] code_of(logic [15:0] v, logic [15:0] l, logic [15:0] h);
		if (v <= l) return RESULT_ALL_ZEROS;
		if (v >= h) return RESULT_ALL_ONES;
		return 10'((32'(v - l) * 1023) / 32'(h - l));
	endfunction : code_of
	task automatic check(logic [9:0] seen, logic [9:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		#(5000 * 25);
		err_count++;
		end_of_test();
	end
	initial begin
		void'($urandom(57413));
		repeat (8) @(posedge ref_clk);
		#1 reset = 1'b0;
		u_apc_host_model.start(1'b1);
		check(10'(sampling), 10'h001);
		for (int i = 0; i < 12; i++) begin
			lo = 16'($urandom_range(0, 32767));
			hi = lo + 16'($urandom_range(1, 32767));
			vin = i == 0 ? lo : i == 1 ? hi : i == 2 ? 16'hffff : 16'($urandom);
			analog = '{vin, lo, hi};
			u_apc_host_model.start(1'b0);
			analog.analog_input = ~vin;
			check(10'(sampling), 10'h000);
			u_apc_host_model.read(got);
			check(got, code_of(vin, lo, hi));
		end
		check(10'(ext_clock_active), 10'h000);
		ext_run = 1'b1;
		repeat (20) @(posedge ref_clk);
		#1 check(10'(ext_clock_active), 10'h001);
		lo = 16'h1000;
		hi = 16'h9000;
		vin = 16'h5000;
		analog = '{vin, lo, hi};
		u_apc_host_model.start(1'b0);
		u_apc_host_model.read(got);
		check(got, code_of(vin, lo, hi));
		ext_run = 1'b0;
		repeat (10) @(posedge ref_clk);
		#1 reset = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 reset = 1'b0;
		check(10'(conv_done_n), 10'h001);
		check(10'(sampling), 10'h001);
		check(result_bus.data_oe, 10'h000);
		check(result_bus.data_out, RESULT_RST);
		check(10'(ext_clock_active), 10'h000);
		repeat (20) @(posedge ref_clk);
		#1 check(10'(ext_clock_active), 10'h000);
		u_apc_host_model.start(1'b0);
		u_apc_host_model.read(got);
		check(got, code_of(vin, lo, hi));
		end_of_test();
	end
endmodule : testbench
